// *** hw/camera_io_line_routing.sv ***
// camera opto i/o line routing with an ahb-lite register slave
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - two input lines, each selectable source
// - four output lines, own source each
// - driver conducts on one, off on zero
// - output one defaults to exposure active
// - output two defaults to trigger ready
// - trigger ready marks earliest next trigger
// - exposure active high during exposure
// - output sources reprogrammable at run time
// - input line edges start acquisition
// - standard mode: line one frame start
// - standard mode: line two acquisition start
// - legacy mode: line one acquisition start
// - one line per trigger, new replaces
module camera_io_line_routing
(
	input  wire logic        clk_i,                 // 20 mhz camera clock
	input  wire logic        rst_i,                 // synchronous reset, high
	input  wire logic        hsel_i,                // slave select
	input  wire logic [31:0] haddr_i,               // byte address
	input  wire logic [1:0]  htrans_i,              // transfer type
	input  wire logic        hwrite_i,              // write when high
	input  wire logic [2:0]  hsize_i,               // transfer size
	input  wire logic [31:0] hwdata_i,              // write data
	input  wire logic        hready_i,              // bus ready
	output logic      [31:0] hrdata_o,              // read data
	output logic             hreadyout_o,           // slave ready
	output logic             hresp_o,               // response
	input  wire logic [1:0]  in_line_i,             // opto input lines
	input  wire logic        exposure_active_out_i, // core exposure level
	input  wire logic        next_trigger_ready_i,  // core trigger ready
	input  wire logic        acq_trigger_wait_i,    // core acq wait level
	output logic      [3:0]  line_out_o,            // opto output drivers
	output logic             external_hw_trigger_frame_o, // frame start pulse
	output logic             external_hw_trigger_acq_o,   // acq start pulse
	output logic             legacy_mode_o          // legacy mode level
);

	// ==============================================================
	// decode helpers
	// resolve a trigger line code to a one-hot input mask
	function automatic logic [1:0] line_mask(input logic [1:0] code,
		input logic [1:0] dflt);
		logic [1:0] c;
		c = (code == io_routing_pkg::TL_DEFAULT) ? dflt : code;
		case (c)
			io_routing_pkg::TL_LINE1: line_mask = 2'h1; // line one
			io_routing_pkg::TL_LINE2: line_mask = 2'h2; // line two
			default:                  line_mask = 2'h0; // unassigned
		endcase
	endfunction

	// pick the wanted edge of the selected line
	function automatic logic edge_hit(input logic [1:0] mask,
		input logic fall, input logic [1:0] now, input logic [1:0] old);
		logic [1:0] e;
		e = fall ? (old & ~now) : (now & ~old);
		edge_hit = |(e & mask);
	endfunction

	// ==============================================================
	// bus address phase capture
	logic        act_q;      // data phase pending
	logic        act_d;      // next pending flag
	logic        wr_q;       // pending transfer is a write
	logic        wr_d;       // next write flag
	logic [3:0]  adr_q;      // pending byte address
	logic [3:0]  adr_d;      // next byte address
	logic        take;       // address phase accepted now

	// a transfer is taken on any selected nonseq or seq with ready high
	always_comb
	begin
		take  = hsel_i & hready_i & htrans_i[1];
		act_d = take;
		wr_d  = take & hwrite_i;
		adr_d = take ? haddr_i[io_routing_pkg::ADDR_MSB:io_routing_pkg::ADDR_LSB]
			: adr_q;
	end

	// address phase registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			act_q <= 1'b0;
			wr_q  <= 1'b0;
			adr_q <= 4'h0;
		end
		else
		begin
			act_q <= act_d;
			wr_q  <= wr_d;
			adr_q <= adr_d;
		end
	end

	// ==============================================================
	// control registers
	logic        legacy_q;   // acquisition mode
	logic        legacy_d;   // next mode
	logic [7:0]  out_src_q;  // per output source fields
	logic [7:0]  out_src_d;  // next source fields
	logic [10:0] trig_sel_q; // trigger line selections
	logic [10:0] trig_sel_d; // next trigger selections
	logic        wdo;        // write data phase now

	// writes land in the data phase; one field per trigger, so a new
	// line code simply overwrites the old assignment
	always_comb
	begin
		wdo        = act_q & wr_q;
		legacy_d   = legacy_q;
		out_src_d  = out_src_q;
		trig_sel_d = trig_sel_q;
		if (wdo)
		begin
			case (adr_q)
				io_routing_pkg::OFS_CTRL:
					legacy_d = hwdata_i[io_routing_pkg::CTRL_LEGACY_BIT];
				io_routing_pkg::OFS_OUT_SRC:
					out_src_d = hwdata_i[7:0];
				io_routing_pkg::OFS_TRIG_SEL:
					trig_sel_d = hwdata_i[10:0];
				default:
					legacy_d = legacy_q; // unmapped or status: ignored
			endcase
		end
	end

	// control state, reset to the power-up defaults
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			legacy_q   <= io_routing_pkg::RST_CTRL[0];
			out_src_q  <= io_routing_pkg::RST_OUT_SRC;
			trig_sel_q <= io_routing_pkg::RST_TRIG_SEL;
		end
		else
		begin
			legacy_q   <= legacy_d;
			out_src_q  <= out_src_d;
			trig_sel_q <= trig_sel_d;
		end
	end

	// ==============================================================
	// input synchronisers and edge history
	logic [1:0]  sync1_q;    // first stage, read only by stage two
	logic [1:0]  sync2_q;    // second stage, safe to use
	logic [1:0]  prev_q;     // previous synced level
	logic [1:0]  frm_mask;   // input feeding frame start
	logic [1:0]  acq_mask;   // input feeding acquisition start
	logic [1:0]  frm_dflt;   // mode default for frame start
	logic [1:0]  acq_dflt;   // mode default for acquisition start
	logic        frm_d;      // next frame start pulse
	logic        acq_d;      // next acquisition start pulse
	logic        frm_q;      // frame start pulse
	logic        acq_q;      // acquisition start pulse

	// mode defaults and edge detection on the second stage only
	always_comb
	begin
		// standard: line one frames, line two acquisitions
		frm_dflt = legacy_q ? io_routing_pkg::TL_NONE
			: io_routing_pkg::TL_LINE1;
		acq_dflt = legacy_q ? io_routing_pkg::TL_LINE1
			: io_routing_pkg::TL_LINE2;
		frm_mask = line_mask(trig_sel_q[io_routing_pkg::FRM_LINE_LSB +: 2],
			frm_dflt);
		acq_mask = line_mask(trig_sel_q[io_routing_pkg::ACQ_LINE_LSB +: 2],
			acq_dflt);
		// legacy mode has no frame start trigger
		frm_d = ~legacy_q & edge_hit(frm_mask,
			trig_sel_q[io_routing_pkg::FRM_FALL_BIT], sync2_q, prev_q);
		acq_d = edge_hit(acq_mask,
			trig_sel_q[io_routing_pkg::ACQ_FALL_BIT], sync2_q, prev_q);
	end

	// two stage synchroniser, history and trigger pulse flops
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
			prev_q  <= 2'h0;
			frm_q   <= 1'b0;
			acq_q   <= 1'b0;
		end
		else
		begin
			sync1_q <= in_line_i;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
			frm_q   <= frm_d;
			acq_q   <= acq_d;
		end
	end

	// ==============================================================
	// output line routing
	logic [3:0]  line_d;     // next output levels
	logic [3:0]  line_q;     // registered output levels

	// one source multiplexer per output line
	genvar g;
	generate
		for (g = 0; g < io_routing_pkg::N_OUT; g = g + 1)
		begin : g_out
			always_comb
			begin
				case (out_src_q[g*io_routing_pkg::SRC_W +: 2])
					io_routing_pkg::SRC_EXPOSURE:
						line_d[g] = exposure_active_out_i;
					io_routing_pkg::SRC_TRIG_RDY:
						line_d[g] = next_trigger_ready_i;
					io_routing_pkg::SRC_ACQ_WAIT:
						line_d[g] = acq_trigger_wait_i & ~legacy_q;
					default:
						line_d[g] = 1'b0; // driver off
				endcase
			end
		end
	endgenerate

	// a one drives the transistor into conduction, a zero turns it off
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			line_q <= 4'h0;
		else
			line_q <= line_d;
	end

	// ==============================================================
	// read data
	logic [31:0] rd_d;       // next read data
	logic [31:0] rd_q;       // read data in data phase
	logic [7:0]  status;     // live status word

	// read mux uses next values so a read right after a write sees it
	always_comb
	begin
		status = '0;
		status[io_routing_pkg::ST_IN_LSB +: 2]  = sync2_q;
		status[io_routing_pkg::ST_OUT_LSB +: 4] = line_q;
		status[io_routing_pkg::ST_EXP_BIT]      = exposure_active_out_i;
		status[io_routing_pkg::ST_RDY_BIT]      = next_trigger_ready_i;
		rd_d = rd_q;
		if (take & ~hwrite_i)
		begin
			case (haddr_i[io_routing_pkg::ADDR_MSB:io_routing_pkg::ADDR_LSB])
				io_routing_pkg::OFS_CTRL:     rd_d = {31'h0, legacy_d};
				io_routing_pkg::OFS_OUT_SRC:  rd_d = {24'h0, out_src_d};
				io_routing_pkg::OFS_TRIG_SEL: rd_d = {21'h0, trig_sel_d};
				io_routing_pkg::OFS_STATUS:   rd_d = {24'h0, status};
				default:                      rd_d = 32'h0; // unmapped
			endcase
		end
	end

	// read data register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rd_q <= 32'h0;
		else
			rd_q <= rd_d;
	end

	// ==============================================================
	// outputs
	assign hrdata_o    = rd_q;
	assign hreadyout_o = 1'b1; // zero wait states
	assign hresp_o     = io_routing_pkg::HRESP_OKAY;
	assign line_out_o  = line_q;
	assign external_hw_trigger_frame_o = frm_q;
	assign external_hw_trigger_acq_o   = acq_q;
	assign legacy_mode_o = legacy_q;

endmodule // camera_io_line_routing

`default_nettype wire

// *** inc/io_routing_pkg.sv ***
// constants shared by the camera i/o line routing block
`default_nettype none
package io_routing_pkg;
	// ==============================================================
	// register byte offsets
	localparam logic [3:0] OFS_CTRL     = 4'h0; // mode control
	localparam logic [3:0] OFS_OUT_SRC  = 4'h4; // output line sources
	localparam logic [3:0] OFS_TRIG_SEL = 4'h8; // trigger input select
	localparam logic [3:0] OFS_STATUS   = 4'hC; // live line status
	localparam int         ADDR_LSB     = 0;    // decoded address low bit
	localparam int         ADDR_MSB     = 3;    // decoded address high bit
	// ==============================================================
	// line counts
	localparam int N_IN  = 2; // physical input lines
	localparam int N_OUT = 4; // physical output lines
	// ==============================================================
	// field positions
	localparam int CTRL_LEGACY_BIT  = 0;  // 1 = legacy acquisition mode
	localparam int SRC_W            = 2;  // width of one source field
	localparam int FRM_LINE_LSB     = 0;  // frame start line code
	localparam int FRM_FALL_BIT     = 2;  // frame start on falling edge
	localparam int ACQ_LINE_LSB     = 8;  // acquisition start line code
	localparam int ACQ_FALL_BIT     = 10; // acquisition start falling edge
	localparam int ST_IN_LSB        = 0;  // synced input levels
	localparam int ST_OUT_LSB       = 2;  // driven output levels
	localparam int ST_EXP_BIT       = 6;  // exposure active level
	localparam int ST_RDY_BIT       = 7;  // trigger ready level
	// ==============================================================
	// output source codes
	localparam logic [1:0] SRC_EXPOSURE = 2'h0; // exposure active
	localparam logic [1:0] SRC_TRIG_RDY = 2'h1; // next trigger ready
	localparam logic [1:0] SRC_ACQ_WAIT = 2'h2; // acquisition trigger wait
	localparam logic [1:0] SRC_OFF      = 2'h3; // driver held off
	// ==============================================================
	// trigger line codes
	localparam logic [1:0] TL_DEFAULT = 2'h0; // line given by the mode
	localparam logic [1:0] TL_LINE1   = 2'h1; // input line one
	localparam logic [1:0] TL_LINE2   = 2'h2; // input line two
	localparam logic [1:0] TL_NONE    = 2'h3; // no line assigned
	// ==============================================================
	// reset values
	localparam logic [0:0]  RST_CTRL     = 1'h0;   // standard mode
	localparam logic [7:0]  RST_OUT_SRC  = 8'hF4;  // exp, rdy, off, off
	localparam logic [10:0] RST_TRIG_SEL = 11'h000; // defaults, rising
	// ==============================================================
	// bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2; // htrans bit 1 marks a transfer
	localparam logic       HRESP_OKAY    = 1'h0; // only response given
endpackage : io_routing_pkg
`default_nettype wire

// *** dv/camera_io_line_routing_sva.sv ***
// assertion checker for the camera i/o line routing block
`timescale 1ns/1ps
`default_nettype none
module camera_io_line_routing_sva
(
	input wire logic        clk_i,                       // clock
	input wire logic        rst_i,                       // reset
	input wire logic        hsel_i,                      // select
	input wire logic [31:0] haddr_i,                     // address
	input wire logic [1:0]  htrans_i,                    // transfer
	input wire logic        hwrite_i,                    // write
	input wire logic [31:0] hwdata_i,                    // wdata
	input wire logic        hready_i,                    // ready in
	input wire logic [31:0] hrdata_o,                    // rdata
	input wire logic        hreadyout_o,                 // ready out
	input wire logic        hresp_o,                     // response
	input wire logic [1:0]  in_line_i,                   // inputs
	input wire logic [3:0]  line_out_o,                  // outputs
	input wire logic        external_hw_trigger_frame_o, // frame
	input wire logic        external_hw_trigger_acq_o,   // acq
	input wire logic        legacy_mode_o                // mode
);
	logic rd_tk; // read address phase taken
	logic wr_tk; // write address phase taken
	assign rd_tk = hsel_i & hready_i & htrans_i[1] & !hwrite_i;
	assign wr_tk = hsel_i & hready_i & htrans_i[1] & hwrite_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========
	// bus answers
	bus_resp_a: assert property (hreadyout_o && !hresp_o)
		else $error("bus answer not ready okay");
	rd_hold_a: assert property (!$past(rd_tk) |-> $stable(hrdata_o))
		else $error("read data moved without read");
	unmap_rd_a: assert property (rd_tk && haddr_i[1:0] != 2'h0 |=> hrdata_o == 32'h0)
		else $error("unmapped read not zero");
	status_out_a: assert property (rd_tk && haddr_i[3:0] == 4'hC |=>
		hrdata_o[5:2] == $past(line_out_o)) else $error("status lines wrong");
	legacy_wr_a: assert property (wr_tk && haddr_i[3:0] == 4'h0 |-> ##2
		legacy_mode_o == $past(hwdata_i[0])) else $error("mode write lost");
	// ==========
	// lines and triggers
	rst_out_a: assert property ($past(rst_i) |-> line_out_o == 4'h0 && !legacy_mode_o)
		else $error("outputs not clear after reset");
	frm_once_a: assert property (external_hw_trigger_frame_o |=> !external_hw_trigger_frame_o)
		else $error("frame pulse too long");
	acq_once_a: assert property (external_hw_trigger_acq_o |=> !external_hw_trigger_acq_o)
		else $error("acq pulse too long");
	legacy_frm_a: assert property (legacy_mode_o && $past(legacy_mode_o)
		|-> !external_hw_trigger_frame_o) else $error("frame pulse in legacy");
	trig_sync_a: assert property (external_hw_trigger_frame_o || external_hw_trigger_acq_o
		|-> $past(in_line_i, 3) != $past(in_line_i, 4)) else $error("pulse without edge");
	frm_c: cover property (external_hw_trigger_frame_o);
	acq_c: cover property (external_hw_trigger_acq_o);
	leg_c: cover property (legacy_mode_o && external_hw_trigger_acq_o);
endmodule // camera_io_line_routing_sva
`default_nettype wire

// *** dv/io_far_side_model.sv ***
// far-side model: trigger sources and output line monitor
`timescale 1ns/1ps
`default_nettype none
module io_far_side_model
(
	input  wire logic       clk_i,      // camera clock
	input  wire logic [3:0] line_out_i, // watched output lines
	output logic      [1:0] line_o      // driven input lines
);
	logic [3:0] seen_q; // last output level seen
	// ==========
	// trigger source: lines change just after an edge
	initial line_o = 2'h0;
	task automatic drive_lines(input logic [1:0] v);
		@(posedge clk_i);
		line_o <= v;
	endtask
	// monitoring equipment samples the drivers mid-cycle, once settled
	always_ff @(negedge clk_i)
		seen_q <= line_out_i;
endmodule // io_far_side_model
`default_nettype wire

// *** dv/tb_camera_io_line_routing.sv ***
// self-checking bench for the camera i/o line routing block
`timescale 1ns/1ps
`default_nettype none
module tb_camera_io_line_routing;
	logic        clk_i, rst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
	logic [1:0]  htrans_i, in_line_i;
	logic [2:0]  hsize_i;
	logic [3:0]  line_out_o;
	logic        exposure_active_out_i, next_trigger_ready_i, acq_trigger_wait_i;
	logic        external_hw_trigger_frame_o, external_hw_trigger_acq_o, legacy_mode_o;
	int          miscompares, comparisons, nf, na; // counts and pulses seen
	localparam logic [7:0] FR = 8'h40, FF = 8'h10, AR = 8'h04, AF = 8'h01; // pulse fields
	camera_io_line_routing camera_io_line_routing_i (.clk_i, .rst_i, .hsel_i, .haddr_i,
		.htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
		.hresp_o, .in_line_i, .exposure_active_out_i, .next_trigger_ready_i,
		.acq_trigger_wait_i, .line_out_o, .external_hw_trigger_frame_o,
		.external_hw_trigger_acq_o, .legacy_mode_o);
	io_far_side_model io_far_side_model_i (.clk_i, .line_out_i(line_out_o), .line_o(in_line_i));
	// ==========
	// clock and pulse counters
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		nf <= nf + int'(external_hw_trigger_frame_o);
		na <= na + int'(external_hw_trigger_acq_o);
	end
	// ==========
	// shared tasks
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task final_report;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task hold_rdy; // bounded wait for hready at an edge
		int n;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (hreadyout_o !== 1'b1 && n < 20);
		if (hreadyout_o !== 1'b1)
		begin
			miscompares++;
			final_report;
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
		@(posedge clk_i);
		hsel_i <= 1'b1;
		haddr_i <= {28'h0, a};
		htrans_i <= io_routing_pkg::HTRANS_NONSEQ;
		hwrite_i <= w;
		hold_rdy;
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		hold_rdy;
		rd = hrdata_o;
	endtask
	task lv(input logic e, input logic r, input logic w); // core levels, then settle
		@(posedge clk_i);
		exposure_active_out_i <= e;
		next_trigger_ready_i <= r;
		acq_trigger_wait_i <= w;
		repeat (2) @(posedge clk_i);
	endtask
	task trig(input logic [1:0] v, input logic [7:0] x, input string m);
		int f0, a0;
		logic [7:0] g;
		f0 = nf;
		a0 = na;
		io_far_side_model_i.drive_lines(v);
		repeat (6) @(posedge clk_i);
		g[7:6] = 2'(nf - f0);
		g[3:2] = 2'(na - a0);
		f0 = nf;
		a0 = na;
		io_far_side_model_i.drive_lines(2'h0);
		repeat (6) @(posedge clk_i);
		g[5:4] = 2'(nf - f0);
		g[1:0] = 2'(na - a0);
		chk({24'h0, g}, {24'h0, x}, m);
	endtask
	// ==========
	// scenarios
	task t_reset;
		bus(1'b0, io_routing_pkg::OFS_CTRL, 32'h0);
		chk(rd, 32'h0, "mode reset");
		bus(1'b0, io_routing_pkg::OFS_OUT_SRC, 32'h0);
		chk(rd, {24'h0, {2{2'h3}}, 2'h1, 2'h0}, "sources reset");
		lv(1'b1, 1'b0, 1'b0);
		chk(32'(line_out_o), 32'h1, "exposure on line one");
		lv(1'b0, 1'b1, 1'b0);
		chk(32'(line_out_o), 32'h2, "ready on line two");
		trig(2'h1, FR, "line one frame");
		trig(2'h2, AR, "line two acq");
		$display("test reset done");
	endtask
	task t_route;
		logic e;
		for (int c = 0; c < 4; c++)
		begin
			e = (c == 0 || c == 2);
			bus(1'b1, io_routing_pkg::OFS_OUT_SRC, {24'h0, {4{2'(c)}}});
			lv(1'b1, 1'b0, 1'b1);
			chk(32'(line_out_o), {28'h0, {4{e}}}, "routed level");
			chk(32'(io_far_side_model_i.seen_q), {28'h0, {4{e}}}, "far side level");
			bus(1'b0, io_routing_pkg::OFS_STATUS, 32'h0);
			chk({26'h0, rd[7:2]}, {28'h1, {4{e}}}, "status levels");
		end
		bus(1'b0, 4'h2, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		$display("test route done");
	endtask
	task t_sel;
		bus(1'b1, io_routing_pkg::OFS_TRIG_SEL, 32'h102); // acq line one, frame line two
		trig(2'h1, AR, "acq moved");
		trig(2'h2, FR, "frame moved");
		bus(1'b1, io_routing_pkg::OFS_TRIG_SEL, 32'h507); // acq line one falling, frame none
		trig(2'h1, AF, "falling acq");
		trig(2'h2, 8'h00, "no line");
		bus(1'b1, io_routing_pkg::OFS_TRIG_SEL, 32'h0);
		$display("test select done");
	endtask
	task t_legacy;
		bus(1'b1, io_routing_pkg::OFS_CTRL, 32'h1);
		bus(1'b1, io_routing_pkg::OFS_OUT_SRC, 32'hAA);
		lv(1'b1, 1'b1, 1'b1);
		chk(32'(line_out_o), 32'h0, "wait off in legacy");
		chk(32'(legacy_mode_o), 32'h1, "legacy mode level");
		trig(2'h1, AR, "legacy line one");
		trig(2'h2, 8'h00, "legacy line two");
		bus(1'b1, io_routing_pkg::OFS_CTRL, 32'h0);
		trig(2'h1, FR, "standard again");
		$display("test legacy done");
	endtask
	// mid-run reset must bring back the default routing and mode
	task t_rerst;
		bus(1'b1, io_routing_pkg::OFS_CTRL, 32'h1);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, io_routing_pkg::OFS_OUT_SRC, 32'h0);
		chk(rd, {24'h0, {2{2'h3}}, 2'h1, 2'h0}, "sources after reset");
		bus(1'b0, io_routing_pkg::OFS_CTRL, 32'h0);
		chk(rd, 32'h0, "mode after reset");
		lv(1'b1, 1'b1, 1'b0);
		chk(32'(line_out_o), 32'h3, "default lines after reset");
		trig(2'h1, FR, "frame after reset");
		$display("test mid-run reset done");
	endtask
	initial
	begin
		{rst_i, hsize_i} = 4'hA;
		{hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = 68'h0;
		{exposure_active_out_i, next_trigger_ready_i, acq_trigger_wait_i} = 3'h0;
		{nf, na, miscompares, comparisons} = 128'h0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_route;
		t_sel;
		t_legacy;
		t_rerst;
		final_report;
	end
endmodule // tb_camera_io_line_routing
bind camera_io_line_routing camera_io_line_routing_sva camera_io_line_routing_sva_i (.clk_i,
	.rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hrdata_o,
	.hreadyout_o, .hresp_o, .in_line_i, .line_out_o, .external_hw_trigger_frame_o,
	.external_hw_trigger_acq_o, .legacy_mode_o);
`default_nettype wire
